// ### hdl/iicrx_pkg.sv
// package for the two-wire receive, crc and baud block
// assumes a single 10 MHz clock and an axi4-lite register slave
//==========================================================================
// Summary of operation
// - slave mode: received byte shows the last byte loaded, address or data, matched or not
// - master mode: received byte shows the last data byte taken from the bus
// - reading received byte clears buffer full and lets the next byte load
// - each load of the received byte register sets the receive interrupt flag
// - crc result register holds crc of last byte while enabled and ready
// - compute crc for every byte moved while enabled, load result and set crc ready in the same cycle
// - reading the crc result register clears the crc ready flag
// - unread crc ready flag is cleared by hardware before next crc loads
// - baud select codes 0..7 divide bus clock by 20 up to 2560
// - on arbitration loss as master release both bus lines at once
// - after arbitration loss without stop the bus busy flag stays set
// - clearing module enable releases the bus and clears bus busy
// - setting module enable again resumes normal operation
// - receive interrupt flag raises the interrupt only with interrupt enable set
package iicrx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_RECEIVED_BYTE = 8'h00;
  localparam logic [7:0] OFS_CRC_RESULT    = 8'h04;
  localparam logic [7:0] OFS_BIT_RATE_DIV  = 8'h08;
  localparam logic [7:0] OFS_CONTROL       = 8'h0c;
  localparam logic [7:0] OFS_STATUS        = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR     = 8'h1c;
  // control fields
  localparam int CTL_MODULE_ENABLE = 0;
  localparam int CTL_IRQ_ENABLE    = 1;
  // status fields
  localparam int STS_RX_FULL    = 0;
  localparam int STS_CRC_READY  = 1;
  localparam int STS_ADDR_MATCH = 2;
  localparam int STS_BUS_BUSY   = 3;
  localparam int STS_MASTER     = 4;
  // interrupt status fields
  localparam int IRQ_RX    = 0;
  localparam int IRQ_CRC   = 1;
  localparam int IRQ_ARBL  = 2;
  localparam int IRQ_WIDTH = 3;
  // reset values
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [1:0] RST_CONTROL = 2'h0;
  // crc-8 polynomial x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY = 8'h07;
  // divisors per baud select code
  localparam logic [11:0] BAUD_DIV_BASE = 12'h014;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {IICRX_IDLE, IICRX_BUSY, IICRX_HUNG} iicrx_bus_t;
endpackage

// ### hdl/iicrx_crc.sv
// per-byte crc-8 engine, one bit per clock
// assumes start is a one-cycle pulse with the byte to fold in
module iicrx_crc (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // request
  input  wire logic       start,
  input  wire logic [7:0] data_in,
  // result
  output logic            done,
  output logic [7:0]      crc_out
);
  logic [7:0] crc_reg, crc_next, sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       done_reg, done_next;

  //==========================================================================
  // bit-serial shift: eight cycles, restarts on each byte
  always_comb begin
    crc_next  = crc_reg;
    sh_next   = sh_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (start) begin
      crc_next = 8'h00;
      sh_next  = data_in;
      cnt_next = 4'h8;
    end else if (cnt_reg != 4'h0) begin
      crc_next = (crc_reg[7] ^ sh_reg[7]) ? ({crc_reg[6:0], 1'b0} ^ iicrx_pkg::CRC_POLY)
                                          : {crc_reg[6:0], 1'b0};
      sh_next  = {sh_reg[6:0], 1'b0};
      cnt_next = cnt_reg - 4'h1;
      done_next = (cnt_reg == 4'h1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      crc_reg  <= 8'h00;
      sh_reg   <= 8'h00;
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      crc_reg  <= crc_next;
      sh_reg   <= sh_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done    = done_reg;
  assign crc_out = crc_reg;
endmodule // iicrx_crc

// ### hdl/iicrx_top.sv
// receive data, crc result, baud divider and bus hang recovery
// assumes the shifter of the serial unit delivers bytes and bus events as pulses
module iicrx_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // shifter side
  input  wire logic        byte_done,
  input  wire logic [7:0]  byte_data,
  input  wire logic        byte_is_addr,
  input  wire logic        address_match_flag,
  input  wire logic        master_mode,
  input  wire logic        start_seen,
  input  wire logic        stop_seen,
  input  wire logic        arb_lost,
  // bus line control and baud tick
  output logic             sda_release,
  output logic             scl_release,
  output logic             baud_tick,
  output logic             module_enable,
  output logic             irq
);
  //==========================================================================
  // register state
  logic [7:0] rx_reg, rx_next, crc_res_reg, crc_res_next, div_reg, div_next;
  logic [1:0] ctl_reg, ctl_next;
  logic       full_reg, full_next, crcrdy_reg, crcrdy_next, match_reg, match_next;
  logic [iicrx_pkg::IRQ_WIDTH-1:0] ists_reg, ists_next, ien_reg, ien_next;
  logic       pend_reg, pend_next;
  logic [7:0] pend_data_reg, pend_data_next;
  logic       pend_addr_reg, pend_addr_next;
  iicrx_pkg::iicrx_bus_t bus_reg, bus_next;
  logic       rel_reg, rel_next, irq_reg, irq_next;
  logic [11:0] bcnt_reg, bcnt_next;
  logic       tick_reg, tick_next;
  // axi state
  logic       aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic       ws_reg, ws_next;
  logic       crc_done;
  logic [7:0] crc_val;
  logic       en, wr_fire, rd_fire, load_rx;
  logic [7:0] rd_addr;

  // baud select code to divisor: doubles per step from 20
  function automatic logic [11:0] divisor(input logic [2:0] code);
    divisor = iicrx_pkg::BAUD_DIV_BASE << code;
  endfunction

  // one decode shared by read and write
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  assign en      = ctl_reg[iicrx_pkg::CTL_MODULE_ENABLE];
  assign wr_fire = aw_reg && w_reg && !bv_reg;
  assign rd_fire = s_axi_arvalid && !rv_reg;
  assign rd_addr = s_axi_araddr;

  iicrx_crc u_crc (
    .clock   (clock),
    .rst_b   (rst_b),
    .start   (byte_done && en),
    .data_in (byte_data),
    .done    (crc_done),
    .crc_out (crc_val)
  );

  //==========================================================================
  // axi4-lite slave: address and data latched independently
  always_comb begin
    aw_next = aw_reg; awa_next = awa_reg; w_next = w_reg; wd_next = wd_reg;
    bv_next = bv_reg; br_next = br_reg; rv_next = rv_reg; rr_next = rr_reg;
    rd_next = rd_reg;
    ws_next = ws_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next  = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next  = 1'b1;
      wd_next = s_axi_wdata;
      // strobe kept with the data: the master may drop it once taken
      ws_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = (is_reg(awa_reg, iicrx_pkg::OFS_BIT_RATE_DIV) ||
                 is_reg(awa_reg, iicrx_pkg::OFS_CONTROL) ||
                 is_reg(awa_reg, iicrx_pkg::OFS_IRQ_ENABLE) ||
                 is_reg(awa_reg, iicrx_pkg::OFS_IRQ_CLEAR)) ? iicrx_pkg::RESP_OKAY
                                                            : iicrx_pkg::RESP_SLVERR;
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (rd_fire) begin
      rv_next = 1'b1;
      rr_next = iicrx_pkg::RESP_OKAY;
      rd_next = 32'h0;
      case (rd_addr)
        iicrx_pkg::OFS_RECEIVED_BYTE: rd_next[7:0] = rx_reg;
        iicrx_pkg::OFS_CRC_RESULT:    rd_next[7:0] = (en && crcrdy_reg) ? crc_res_reg : 8'h00;
        iicrx_pkg::OFS_BIT_RATE_DIV:  rd_next[7:0] = div_reg;
        iicrx_pkg::OFS_CONTROL:       rd_next[1:0] = ctl_reg;
        iicrx_pkg::OFS_STATUS:        rd_next[4:0] = {master_mode, bus_reg != iicrx_pkg::IICRX_IDLE,
                                                      match_reg, crcrdy_reg, full_reg};
        iicrx_pkg::OFS_IRQ_STATUS:    rd_next[iicrx_pkg::IRQ_WIDTH-1:0] = ists_reg;
        iicrx_pkg::OFS_IRQ_ENABLE:    rd_next[iicrx_pkg::IRQ_WIDTH-1:0] = ien_reg;
        iicrx_pkg::OFS_IRQ_CLEAR:     rd_next = 32'h0;
        default:                      rr_next = iicrx_pkg::RESP_SLVERR;
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  //==========================================================================
  // data path: received byte, crc, flags and bus state
  always_comb begin
    rx_next = rx_reg; full_next = full_reg; match_next = match_reg;
    crc_res_next = crc_res_reg; crcrdy_next = crcrdy_reg;
    div_next = div_reg; ctl_next = ctl_reg; ien_next = ien_reg; ists_next = ists_reg;
    pend_next = pend_reg; pend_data_next = pend_data_reg; pend_addr_next = pend_addr_reg;
    bus_next = bus_reg; rel_next = rel_reg;
    load_rx = 1'b0;
    // software reads clear flags first so that hardware sets below win
    if (rd_fire && is_reg(rd_addr, iicrx_pkg::OFS_RECEIVED_BYTE))
      full_next = 1'b0;
    if (rd_fire && is_reg(rd_addr, iicrx_pkg::OFS_CRC_RESULT))
      crcrdy_next = 1'b0;
    if (wr_fire && ws_reg) begin
      if (is_reg(awa_reg, iicrx_pkg::OFS_BIT_RATE_DIV)) div_next = wd_reg[7:0];
      if (is_reg(awa_reg, iicrx_pkg::OFS_CONTROL))      ctl_next = wd_reg[1:0];
      if (is_reg(awa_reg, iicrx_pkg::OFS_IRQ_ENABLE))
        ien_next = wd_reg[iicrx_pkg::IRQ_WIDTH-1:0];
      if (is_reg(awa_reg, iicrx_pkg::OFS_IRQ_CLEAR))
        ists_next = ists_reg & ~wd_reg[iicrx_pkg::IRQ_WIDTH-1:0];
    end
    // a byte waits in the holding slot while the register is still full
    if (byte_done && en) begin
      pend_next      = 1'b1;
      pend_data_next = byte_data;
      pend_addr_next = byte_is_addr;
    end
    // gated by enable: a byte caught at the disable edge is dropped
    if (pend_reg && en && !full_next && !byte_done) begin
      load_rx   = 1'b1;
      rx_next   = pend_data_reg;
      // match set only for a matched address in slave mode; data byte clears match
      match_next = pend_addr_reg && address_match_flag && !master_mode;
      full_next = 1'b1;
      pend_next = 1'b0;
      ists_next[iicrx_pkg::IRQ_RX] = 1'b1;
    end
    // a new byte starts the crc: stale ready flag dropped before reload
    if (byte_done && en)
      crcrdy_next = 1'b0;
    if (crc_done) begin
      crc_res_next = crc_val;
      crcrdy_next  = 1'b1;
      ists_next[iicrx_pkg::IRQ_CRC] = 1'b1;
    end
    // bus busy tracking and line release
    case (bus_reg)
      iicrx_pkg::IICRX_IDLE: if (start_seen) bus_next = iicrx_pkg::IICRX_BUSY;
      iicrx_pkg::IICRX_BUSY: begin
        if (stop_seen) bus_next = iicrx_pkg::IICRX_IDLE;
        else if (arb_lost && master_mode) begin
          bus_next = iicrx_pkg::IICRX_HUNG;
          rel_next = 1'b1;
          ists_next[iicrx_pkg::IRQ_ARBL] = 1'b1;
        end
      end
      iicrx_pkg::IICRX_HUNG: if (stop_seen) bus_next = iicrx_pkg::IICRX_IDLE;
      default: bus_next = iicrx_pkg::IICRX_IDLE;
    endcase
    if (bus_next == iicrx_pkg::IICRX_IDLE) rel_next = 1'b0;
    // disabling clears the busy flag and the rx interrupt; re-enable starts idle
    if (!en) begin
      bus_next  = iicrx_pkg::IICRX_IDLE;
      rel_next  = 1'b1;
      full_next = 1'b0;
      pend_next = 1'b0;
      match_next = 1'b0;
      ists_next[iicrx_pkg::IRQ_RX] = 1'b0;
    end else if (!ctl_reg[iicrx_pkg::CTL_MODULE_ENABLE] == 1'b0 && bus_reg == bus_next &&
                 bus_reg == iicrx_pkg::IICRX_IDLE) begin
      rel_next = 1'b0;
    end
  end

  //==========================================================================
  // baud counter: one tick per selected divisor
  always_comb begin
    bcnt_next = bcnt_reg + 12'h001;
    tick_next = 1'b0;
    if (!en) begin
      bcnt_next = 12'h000;
    end else if (bcnt_reg >= divisor(div_reg[2:0]) - 12'h001) begin
      bcnt_next = 12'h000;
      tick_next = 1'b1;
    end
    irq_next = |(ists_next & ien_next) && ctl_next[iicrx_pkg::CTL_IRQ_ENABLE];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_reg <= 1'b0; awa_reg <= 8'h00; w_reg <= 1'b0; wd_reg <= 32'h0;
      bv_reg <= 1'b0; br_reg <= 2'h0; rv_reg <= 1'b0; rr_reg <= 2'h0; rd_reg <= 32'h0;
      ws_reg <= 1'b0;
      rx_reg <= 8'h00; full_reg <= 1'b0; match_reg <= 1'b0;
      crc_res_reg <= 8'h00; crcrdy_reg <= 1'b0;
      div_reg <= iicrx_pkg::RST_DIVIDER; ctl_reg <= iicrx_pkg::RST_CONTROL;
      ien_reg <= '0; ists_reg <= '0;
      pend_reg <= 1'b0; pend_data_reg <= 8'h00; pend_addr_reg <= 1'b0;
      bus_reg <= iicrx_pkg::IICRX_IDLE; rel_reg <= 1'b1;
      bcnt_reg <= 12'h000; tick_reg <= 1'b0; irq_reg <= 1'b0;
    end else begin
      aw_reg <= aw_next; awa_reg <= awa_next; w_reg <= w_next; wd_reg <= wd_next;
      bv_reg <= bv_next; br_reg <= br_next; rv_reg <= rv_next; rr_reg <= rr_next;
      rd_reg <= rd_next;
      ws_reg <= ws_next;
      rx_reg <= rx_next; full_reg <= full_next; match_reg <= match_next;
      crc_res_reg <= crc_res_next; crcrdy_reg <= crcrdy_next;
      div_reg <= div_next; ctl_reg <= ctl_next; ien_reg <= ien_next; ists_reg <= ists_next;
      pend_reg <= pend_next; pend_data_reg <= pend_data_next; pend_addr_reg <= pend_addr_next;
      bus_reg <= bus_next; rel_reg <= rel_next;
      bcnt_reg <= bcnt_next; tick_reg <= tick_next; irq_reg <= irq_next;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = !aw_reg;
  assign s_axi_wready  = !w_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign sda_release   = rel_reg;
  assign scl_release   = rel_reg;
  assign baud_tick     = tick_reg;
  assign module_enable = ctl_reg[iicrx_pkg::CTL_MODULE_ENABLE];
  assign irq           = irq_reg;

  //==========================================================================
  // checks
  chk_arb_release: assert property (@(posedge clock) disable iff (!rst_b)
    (bus_reg == iicrx_pkg::IICRX_BUSY && arb_lost && master_mode && !stop_seen && en)
      |=> sda_release && scl_release) else $error("lines not released on arbitration loss");
  chk_rx_read_clear: assert property (@(posedge clock) disable iff (!rst_b)
    (rd_fire && is_reg(rd_addr, iicrx_pkg::OFS_RECEIVED_BYTE) && !pend_reg) |=> !full_reg)
    else $error("buffer full not cleared by read");
  chk_rx_flag_set: assert property (@(posedge clock) disable iff (!rst_b)
    load_rx |=> ists_reg[iicrx_pkg::IRQ_RX] && full_reg) else $error("rx flag not set on load");
  chk_crc_ready: assert property (@(posedge clock) disable iff (!rst_b)
    crc_done |=> crcrdy_reg && crc_res_reg == $past(crc_val)) else $error("crc not loaded");
  chk_crc_stale: assert property (@(posedge clock) disable iff (!rst_b)
    (byte_done && en) |=> !crcrdy_reg) else $error("stale crc ready kept");
  chk_crc_read: assert property (@(posedge clock) disable iff (!rst_b)
    (rd_fire && is_reg(rd_addr, iicrx_pkg::OFS_CRC_RESULT) && !crc_done) |=> !crcrdy_reg)
    else $error("crc ready not cleared by read");
  chk_disable_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !en |=> bus_reg == iicrx_pkg::IICRX_IDLE && rel_reg) else $error("disable did not free bus");
  chk_hung_holds: assert property (@(posedge clock) disable iff (!rst_b)
    (bus_reg == iicrx_pkg::IICRX_HUNG && !stop_seen && en) |=> bus_reg == iicrx_pkg::IICRX_HUNG)
    else $error("hang state left without stop");
  chk_irq_gate: assert property (@(posedge clock) disable iff (!rst_b)
    !ctl_reg[iicrx_pkg::CTL_IRQ_ENABLE] |-> !irq_reg)
    else $error("irq without enable");
  chk_baud_tick: assert property (@(posedge clock) disable iff (!rst_b)
    (tick_reg && en && $stable(div_reg)) |=> (!tick_reg)[*2]) else $error("baud ticks too close");
  cov_rx_load:  cover property (@(posedge clock) disable iff (!rst_b) load_rx);
  cov_crc_done: cover property (@(posedge clock) disable iff (!rst_b) crc_done);
  cov_hang:     cover property (@(posedge clock) disable iff (!rst_b)
    bus_reg == iicrx_pkg::IICRX_HUNG);
  cov_irq:      cover property (@(posedge clock) disable iff (!rst_b) irq_reg);
  chk_data_unmatch: assert property (@(posedge clock) disable iff (!rst_b)
    (load_rx && !pend_addr_reg) |=> !match_reg) else $error("match kept on data byte");
  cov_recover:  cover property (@(posedge clock) disable iff (!rst_b)
    bus_reg == iicrx_pkg::IICRX_HUNG && !en);
endmodule // iicrx_top

// ### verif/iicrx_far_model.sv
// far-side model: byte and bus events of the two-wire bus as the shifter reports them
// assumes the bench calls its tasks; every output changes right after a rising edge
module iicrx_far_model (
  // clock
  input  wire logic       clock,
  // byte and bus events
  output logic            byte_done,
  output logic [7:0]      byte_data,
  output logic            byte_is_addr,
  output logic            address_match_flag,
  output logic            master_mode,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            arb_lost
);
  timeunit 1ns;
  timeprecision 1ns;
  //==========================================================================
  // idle bus at time zero
  initial begin
    {byte_done, byte_data, byte_is_addr, address_match_flag} = '0;
    {master_mode, start_seen, stop_seen, arb_lost} = '0;
  end
  // one byte; data lines are scrambled after the pulse so stale values never pass
  task automatic put_byte(input logic [7:0] d, input logic is_addr, input logic match,
                          input logic ms);
    @(posedge clock);
    byte_done <= 1'b1;
    byte_data <= d;
    byte_is_addr <= is_addr;
    address_match_flag <= match;
    master_mode <= ms;
    @(posedge clock);
    byte_done <= 1'b0;
    byte_data <= ~d;
    byte_is_addr <= ~is_addr;
    // the crc engine needs nine cycles between bytes
    repeat (11) @(posedge clock);
  endtask
  // one-cycle bus condition: 0 start, 1 stop, 2 arbitration lost
  task automatic bus_event(input int k, input logic ms);
    @(posedge clock);
    master_mode <= ms;
    start_seen <= (k == 0);
    stop_seen <= (k == 1);
    arb_lost <= (k == 2);
    @(posedge clock);
    {start_seen, stop_seen, arb_lost} <= 3'h0;
  endtask
endmodule // iicrx_far_model

// ### verif/tb_top.sv
// self-checking bench for the receive, crc, baud and hang recovery block
// assumes the far-side model in iicrx_far_model.sv and the design package
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  //==========================================================================
  // signals
  logic clock = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, v;
  logic byte_done, byte_is_addr, address_match_flag, master_mode;
  logic start_seen, stop_seen, arb_lost;
  logic [7:0] byte_data;
  logic sda_release, scl_release, baud_tick, module_enable, irq;
  int miscompares = 0, checks = 0, cycles = 0;
  // 10 MHz clock
  always #50 clock = ~clock;
  iicrx_top u_dut (.clock(clock), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .byte_done(byte_done),
    .byte_data(byte_data), .byte_is_addr(byte_is_addr), .address_match_flag(address_match_flag),
    .master_mode(master_mode), .start_seen(start_seen), .stop_seen(stop_seen),
    .arb_lost(arb_lost), .sda_release(sda_release), .scl_release(scl_release),
    .baud_tick(baud_tick), .module_enable(module_enable), .irq(irq));
  iicrx_far_model u_far (.clock(clock), .byte_done(byte_done), .byte_data(byte_data),
    .byte_is_addr(byte_is_addr), .address_match_flag(address_match_flag),
    .master_mode(master_mode), .start_seen(start_seen), .stop_seen(stop_seen),
    .arb_lost(arb_lost));
  //==========================================================================
  // closing report
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the roughly 16000 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict();
    end
  end
  //==========================================================================
  // axi4-lite master: the first edge keeps back-to-back calls from touching one signal twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (++n > 100) begin
        miscompares++;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (++n > 100) begin
        miscompares++;
        break;
      end
    end
  endtask
  // crc-8 of one byte alone, msb first, zero start value
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c = d;
    for (int i = 0; i < 8; i++) c = c[7] ? ({c[6:0], 1'b0} ^ iicrx_pkg::CRC_POLY) : {c[6:0], 1'b0};
    return c;
  endfunction
  //==========================================================================
  // scenarios
  task automatic t_regs();
    rd(iicrx_pkg::OFS_BIT_RATE_DIV, v, rs);
    `CHK("divider reset", iicrx_pkg::RST_DIVIDER, v[7:0])
    wr(iicrx_pkg::OFS_BIT_RATE_DIV, 32'h3, rs);
    rd(iicrx_pkg::OFS_BIT_RATE_DIV, v, rs);
    `CHK("divider readback", 3'h3, v[2:0])
    rd(8'h20, v, rs);
    `CHK("unmapped read resp", iicrx_pkg::RESP_SLVERR, rs)
    wr(iicrx_pkg::OFS_RECEIVED_BYTE, 32'h5, rs);
    `CHK("read-only write resp", iicrx_pkg::RESP_SLVERR, rs)
    $display("test regs done");
  endtask
  task automatic t_baud();
    int n;
    wr(iicrx_pkg::OFS_CONTROL, 32'h1, rs);
    for (int code = 0; code < 8; code++) begin
      wr(iicrx_pkg::OFS_BIT_RATE_DIV, code, rs);
      // skip two intervals, the first of which may still run on the old divisor
      repeat (2) begin
        n = 0;
        do begin @(posedge clock); n++; end while (baud_tick !== 1'b1 && n < 6000);
      end
      n = 0;
      do begin @(posedge clock); n++; end while (baud_tick !== 1'b1 && n < 6000);
      `CHK("baud period", iicrx_pkg::BAUD_DIV_BASE << code, 12'(n))
    end
    wr(iicrx_pkg::OFS_BIT_RATE_DIV, 32'h3, rs);
    $display("test baud done");
  endtask
  task automatic t_rx();
    wr(iicrx_pkg::OFS_IRQ_ENABLE, 32'h1, rs);
    u_far.put_byte(8'ha6, 1'b1, 1'b1, 1'b0);
    rd(iicrx_pkg::OFS_STATUS, v, rs);
    `CHK("rx full set", 1'b1, v[iicrx_pkg::STS_RX_FULL])
    `CHK("irq masked", 1'b0, irq)
    wr(iicrx_pkg::OFS_CONTROL, 32'h3, rs);
    @(posedge clock);
    `CHK("irq raised", 1'b1, irq)
    rd(iicrx_pkg::OFS_IRQ_STATUS, v, rs);
    `CHK("rx irq flag", 1'b1, v[iicrx_pkg::IRQ_RX])
    rd(iicrx_pkg::OFS_RECEIVED_BYTE, v, rs);
    `CHK("calling address", 8'ha6, v[7:0])
    rd(iicrx_pkg::OFS_STATUS, v, rs);
    `CHK("rx full cleared", 1'b0, v[iicrx_pkg::STS_RX_FULL])
    wr(iicrx_pkg::OFS_IRQ_CLEAR, 32'h1, rs);
    @(posedge clock);
    `CHK("irq cleared", 1'b0, irq)
    // two bytes with no read between: the second waits for the first read
    u_far.put_byte(8'h5a, 1'b0, 1'b0, 1'b0);
    u_far.put_byte(8'h3c, 1'b0, 1'b0, 1'b0);
    rd(iicrx_pkg::OFS_RECEIVED_BYTE, v, rs);
    `CHK("slave data", 8'h5a, v[7:0])
    rd(iicrx_pkg::OFS_RECEIVED_BYTE, v, rs);
    `CHK("next byte loaded", 8'h3c, v[7:0])
    `CHK("irq on reload", 1'b1, irq)
    u_far.put_byte(8'h99, 1'b0, 1'b0, 1'b1);
    rd(iicrx_pkg::OFS_RECEIVED_BYTE, v, rs);
    `CHK("master data", 8'h99, v[7:0])
    wr(iicrx_pkg::OFS_IRQ_CLEAR, 32'h7, rs);
    $display("test rx done");
  endtask
  task automatic t_crc();
    u_far.put_byte(8'hc5, 1'b0, 1'b0, 1'b0);
    rd(iicrx_pkg::OFS_STATUS, v, rs);
    `CHK("crc ready set", 1'b1, v[iicrx_pkg::STS_CRC_READY])
    rd(iicrx_pkg::OFS_CRC_RESULT, v, rs);
    `CHK("crc value", crc8(8'hc5), v[7:0])
    rd(iicrx_pkg::OFS_STATUS, v, rs);
    `CHK("crc ready cleared", 1'b0, v[iicrx_pkg::STS_CRC_READY])
    u_far.put_byte(8'h11, 1'b0, 1'b0, 1'b0);
    u_far.put_byte(8'h22, 1'b0, 1'b0, 1'b0);
    rd(iicrx_pkg::OFS_CRC_RESULT, v, rs);
    `CHK("crc of newest byte", crc8(8'h22), v[7:0])
    $display("test crc done");
  endtask
  task automatic t_hang();
    u_far.bus_event(0, 1'b1);
    u_far.bus_event(2, 1'b1);
    @(posedge clock);
    `CHK("lines released", 2'h3, {sda_release, scl_release})
    repeat (50) @(posedge clock);
    rd(iicrx_pkg::OFS_STATUS, v, rs);
    `CHK("bus stays busy", 1'b1, v[iicrx_pkg::STS_BUS_BUSY])
    // software timeout expired: without a stop, disabling is the only way out
    wr(iicrx_pkg::OFS_CONTROL, 32'h0, rs);
    rd(iicrx_pkg::OFS_STATUS, v, rs);
    `CHK("busy cleared", 1'b0, v[iicrx_pkg::STS_BUS_BUSY])
    `CHK("released on disable", 3'h7, {sda_release, scl_release, ~module_enable})
    wr(iicrx_pkg::OFS_CONTROL, 32'h1, rs);
    u_far.bus_event(0, 1'b0);
    u_far.put_byte(8'h77, 1'b0, 1'b0, 1'b0);
    rd(iicrx_pkg::OFS_RECEIVED_BYTE, v, rs);
    `CHK("resumed receive", 8'h77, v[7:0])
    $display("test hang done");
  endtask
  //==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_baud();
    t_rx();
    t_crc();
    t_hang();
    print_verdict();
  end
endmodule // tb_top
